//--- qec_pkg.sv
// constants, field layout and types of the encoder counter control block
package qec_pkg;

   // register byte offsets
   localparam logic [7:0] QEC_OFS_CONTROL   = 8'h00;
   localparam logic [7:0] QEC_OFS_POSITION  = 8'h04;
   localparam logic [7:0] QEC_OFS_VELOCITY  = 8'h08;
   localparam logic [7:0] QEC_OFS_VEL_HOLD  = 8'h0C;
   localparam logic [7:0] QEC_OFS_INT_TIMER = 8'h10;
   localparam logic [7:0] QEC_OFS_INT_HOLD  = 8'h14;
   localparam logic [7:0] QEC_OFS_INDEX     = 8'h18;

   // encoder_control field positions
   localparam int QEC_MODE_LSB  = 0;
   localparam int QEC_EXTERNAL_GATE_ENABLE_BIT = 2;
   localparam int QEC_POL_BIT   = 3;
   localparam int QEC_DIV_LSB   = 4;
   localparam int QEC_POSITION_INIT_MODE_LSB = 8;
   localparam int QEC_IMV_LSB   = 12;

   // writable bits of encoder_control, the rest read as zero
   localparam logic [31:0] QEC_CONTROL_MASK  = 32'h0000_377F;
   localparam logic [31:0] QEC_CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] QEC_COUNT_RESET   = 32'h0000_0000;

   // prescaler counter width, enough for 1:128
   localparam int QEC_DIV_BITS = 7;

   // ahb-lite encodings
   localparam logic [2:0] QEC_HSIZE_WORD = 3'h2;
   localparam logic       QEC_HRESP_OKAY = 1'h0;

   typedef enum logic [1:0] {
      QEC_MODE_X4       = 2'h0,
      QEC_MODE_EXT_DIR  = 2'h1,
      QEC_MODE_EXT_GATE = 2'h2,
      QEC_MODE_TIMER    = 2'h3
   } qec_mode_type;

   typedef enum logic {QEC_BUS_IDLE, QEC_BUS_READ} qec_bus_state_type;

endpackage : qec_pkg

//--- qec_tick_if.sv
// prescale select and counter tick between control logic and divider
`timescale 1ns/100ps
interface qec_tick_if;
   logic [2:0] sel;
   logic       tick;
   modport ctrl (output sel, input tick);
   modport div  (input sel, output tick);
endinterface : qec_tick_if

//--- qec_prescaler.sv
// power-of-two divider of the counter clock
`timescale 1ns/100ps
module qec_prescaler
   import qec_pkg::*;
(
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // select and tick
   qec_tick_if.div   tk
);

   logic [QEC_DIV_BITS-1:0] cnt_q;
   logic [QEC_DIV_BITS-1:0] mask;
   logic                    tick_q;

   // mask holds sel low ones: the tick fires once every 2**sel cycles
   always_comb begin
      mask = QEC_DIV_BITS'((8'h01 << tk.sel) - 8'h01);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 7'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= ((cnt_q & mask) == mask); // [RQ1]
      end
   end

   assign tk.tick = tick_q;

   a_div_bypass: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ1]
      $past(hresetn) && $past(tk.sel) == 3'h0 |-> tk.tick)
      else $error("1:1 prescale did not tick every cycle");

   a_div_spacing: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ1]
      tk.tick && $stable(tk.sel) && tk.sel != 3'h0 |=> !tk.tick)
      else $error("divided tick came on two cycles in a row");

endmodule : qec_prescaler

//--- qec_counter_ctrl.sv
// encoder counter control with ahb-lite register slave
// Summary of operation
// RQ1: three-bit prescale divides the counter clock by 1 up to 128.
// RQ2: polarity 1 counts down, 0 counts up, unless an external direction overrides.
// RQ3: gate enable 1 lets the gate signal stop counting; 0 ignores it.
// RQ4: mode 11 is an internal timer, phase B gates it when enabled.
// RQ5: mode 10 counts phase A edges, phase B gates them when enabled.
// RQ6: mode 01 counts phase A edges, phase B high up, low down.
// RQ7: mode 00 is x4 quadrature counting of phases A and B.
// RQ8: modes 01, 10, 11 run all counters as timers, init mode ignored.
// RQ9: mode 00 resets the position count when phases equal the match value.
// RQ10: software should pick a counter clock twice the top count rate.
// RQ11: reading the velocity counter copies it into velocity hold at once.
// RQ12: each count pulse moves interval timer into interval hold and clears it.
// RQ13: x4 mode steps on every edge of either phase, leading phase sets direction. The code drops edges of both phases in one cycle.
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
module qec_counter_ctrl
   import qec_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic [31:0] hrdata,
   output      logic        hreadyout,
   output      logic        hresp,
   // encoder inputs
   input  wire logic        phase_a_input,
   input  wire logic        phase_b_input,
   input  wire logic        gate_input
);

   qec_tick_if tk ();

   qec_prescaler u_prescaler (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tk      (tk)
   );

   // registers
   logic [31:0]       ctrl_q;
   logic [31:0]       pos_q;
   logic [31:0]       vel_q;
   logic [31:0]       vel_hold_q;
   logic [31:0]       int_tmr_q;
   logic [31:0]       int_hold_q;
   logic [31:0]       idx_q;
   logic              a_prev_q;
   logic              b_prev_q;
   logic              match_prev_q;
   // bus state
   qec_bus_state_type state_q;
   logic              wr_pend_q;
   logic [7:0]        wr_addr_q;
   logic [7:0]        rd_addr_q;
   logic [31:0]       hrdata_q;
   logic              hreadyout_q;
   logic              hresp_q;
   // decoded control and events
   qec_mode_type      mode;
   logic              external_gate_enable;
   logic              pol;
   logic [1:0]        index_match_value;
   logic              req;
   logic              wr_en;
   logic              a_rise;
   logic              x4_edge;
   logic              x4_up;
   logic              gate_level;
   logic              gate_ok;
   logic              raw_pulse;
   logic              pulse;
   logic              up;
   logic              match;
   logic              idx_step;
   logic              vel_capture;
   logic [31:0]       rd_mux;

   assign mode   = qec_mode_type'(ctrl_q[QEC_MODE_LSB +: 2]);
   assign external_gate_enable  = ctrl_q[QEC_EXTERNAL_GATE_ENABLE_BIT];
   assign pol    = ctrl_q[QEC_POL_BIT];
   assign index_match_value    = ctrl_q[QEC_IMV_LSB +: 2];
   assign tk.sel = ctrl_q[QEC_DIV_LSB +: 3]; // [RQ1]

   // count event decoding

   assign a_rise  = phase_a_input & ~a_prev_q;
   // exactly one phase changed: a both-phase jump is a glitch and is dropped
   assign x4_edge = (phase_a_input ^ a_prev_q) ^ (phase_b_input ^ b_prev_q); // [RQ13]
   assign x4_up   = ~(a_prev_q ^ phase_b_input); // [RQ13]

   // phase B is the gate in modes 10 and 11, the gate pin elsewhere
   always_comb begin
      gate_level = gate_input;
      if (mode == QEC_MODE_EXT_GATE || mode == QEC_MODE_TIMER) begin
         gate_level = phase_b_input; // [RQ4] [RQ5]
      end
   end

   assign gate_ok = !external_gate_enable || gate_level; // [RQ3]

   always_comb begin
      raw_pulse = 1'b0;
      up        = ~pol; // [RQ2]
      unique case (mode)
         QEC_MODE_X4: begin
            raw_pulse = x4_edge; // [RQ7] [RQ13]
            up        = x4_up ^ pol; // [RQ2]
         end
         QEC_MODE_EXT_DIR: begin
            raw_pulse = a_rise; // [RQ6]
            up        = phase_b_input; // [RQ6]
         end
         QEC_MODE_EXT_GATE: begin
            raw_pulse = a_rise; // [RQ5]
         end
         QEC_MODE_TIMER: begin
            raw_pulse = tk.tick; // [RQ4]
         end
      endcase
   end

   assign pulse = raw_pulse && gate_ok; // [RQ3]

   // imv bit 1 matches phase A, bit 0 phase B; init mode only applies in x4
   assign match = (mode == QEC_MODE_X4) && ({phase_a_input, phase_b_input} == index_match_value); // [RQ8] [RQ9]

   // index counter follows match entries in x4, the count pulse as a timer
   assign idx_step = (mode == QEC_MODE_X4) ? (match && !match_prev_q) : pulse; // [RQ8]

   // idle pins sit on the default match value, so no false index step after reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_prev_q     <= 1'b0;
         b_prev_q     <= 1'b0;
         match_prev_q <= 1'b1;
      end else begin
         a_prev_q     <= phase_a_input;
         b_prev_q     <= phase_b_input;
         match_prev_q <= match;
      end
   end

   // ahb-lite slave

   assign req   = hsel && htrans[1] && hready;
   assign wr_en = wr_pend_q;

   // writes finish with no wait; a read takes one wait state so that it
   // sees a write still in its data phase and samples the counters once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= req && hwrite && (hsize == QEC_HSIZE_WORD);
         if (req) begin
            wr_addr_q <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q     <= QEC_BUS_IDLE;
         rd_addr_q   <= 8'h00;
         hreadyout_q <= 1'b1;
      end else begin
         unique case (state_q)
            QEC_BUS_IDLE: begin
               if (req && !hwrite) begin
                  state_q     <= QEC_BUS_READ;
                  rd_addr_q   <= haddr[7:0];
                  hreadyout_q <= 1'b0;
               end
            end
            QEC_BUS_READ: begin
               state_q     <= QEC_BUS_IDLE;
               hreadyout_q <= 1'b1;
            end
         endcase
      end
   end

   always_comb begin
      unique case (rd_addr_q)
         QEC_OFS_CONTROL:   rd_mux = ctrl_q;
         QEC_OFS_POSITION:  rd_mux = pos_q;
         QEC_OFS_VELOCITY:  rd_mux = vel_q;
         QEC_OFS_VEL_HOLD:  rd_mux = vel_hold_q;
         QEC_OFS_INT_TIMER: rd_mux = int_tmr_q;
         QEC_OFS_INT_HOLD:  rd_mux = int_hold_q;
         QEC_OFS_INDEX:     rd_mux = idx_q;
         default:           rd_mux = 32'h0000_0000;
      endcase
   end

   assign vel_capture = (state_q == QEC_BUS_READ) && (rd_addr_q == QEC_OFS_VELOCITY);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (state_q == QEC_BUS_READ) begin
         hrdata_q <= rd_mux;
      end
   end

   // no error case exists, every transfer answers okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp_q <= QEC_HRESP_OKAY;
      end else begin
         hresp_q <= QEC_HRESP_OKAY;
      end
   end

   assign hrdata    = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp     = hresp_q;

   // registers and counters

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= QEC_CONTROL_RESET;
      end else if (wr_en && wr_addr_q == QEC_OFS_CONTROL) begin
         ctrl_q <= hwdata & QEC_CONTROL_MASK;
      end
   end

   // a software write beats an index match, which beats a count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pos_q <= QEC_COUNT_RESET;
      end else if (wr_en && wr_addr_q == QEC_OFS_POSITION) begin
         pos_q <= hwdata;
      end else if (match) begin
         pos_q <= QEC_COUNT_RESET; // [RQ9]
      end else if (pulse) begin
         pos_q <= up ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001; // [RQ2]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vel_q <= QEC_COUNT_RESET;
      end else if (pulse) begin
         vel_q <= up ? vel_q + 32'h0000_0001 : vel_q - 32'h0000_0001;
      end
   end

   // hold and hrdata load on the same edge from the same counter value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vel_hold_q <= QEC_COUNT_RESET;
      end else if (vel_capture) begin
         vel_hold_q <= vel_q; // [RQ11]
      end else if (wr_en && wr_addr_q == QEC_OFS_VEL_HOLD) begin
         vel_hold_q <= hwdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_tmr_q <= QEC_COUNT_RESET;
      end else if (pulse) begin
         int_tmr_q <= QEC_COUNT_RESET; // [RQ12]
      end else if (tk.tick) begin
         int_tmr_q <= int_tmr_q + 32'h0000_0001; // [RQ1]
      end
   end

   // a pulse wins over a software write of the hold in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_hold_q <= QEC_COUNT_RESET;
      end else if (pulse) begin
         int_hold_q <= int_tmr_q; // [RQ12]
      end else if (wr_en && wr_addr_q == QEC_OFS_INT_HOLD) begin
         int_hold_q <= hwdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idx_q <= QEC_COUNT_RESET;
      end else if (idx_step) begin
         idx_q <= up ? idx_q + 32'h0000_0001 : idx_q - 32'h0000_0001; // [RQ2]
      end
   end

   // checks

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   logic pos_wr;
   assign pos_wr = wr_en && wr_addr_q == QEC_OFS_POSITION;

   sequence s_vel_read;
      req && !hwrite && haddr[7:0] == QEC_OFS_VELOCITY ##1 !hreadyout_q;
   endsequence

   sequence s_timer_stopped;
      mode == QEC_MODE_TIMER && external_gate_enable && !phase_b_input && !pos_wr;
   endsequence

   a_index_reset: assert property ( // [RQ9]
      mode == QEC_MODE_X4 && {phase_a_input, phase_b_input} == index_match_value && !pos_wr
      |=> pos_q == 32'h0000_0000)
      else $error("index match did not clear position");

   a_dir_negative: assert property ( // [RQ2]
      mode == QEC_MODE_TIMER && pol && pulse && !pos_wr
      |=> pos_q == $past(pos_q) - 32'h0000_0001)
      else $error("negative polarity timer did not count down");

   a_gate_holds: assert property ( // [RQ3]
      external_gate_enable && !gate_level && !pos_wr && !match |=> $stable(pos_q))
      else $error("position moved while gate closed");

   a_timer_stop: assert property ( // [RQ4]
      s_timer_stopped |=> $stable(pos_q) && $stable(vel_q))
      else $error("gated timer kept running");

   a_timer_run: assert property ( // [RQ4]
      mode == QEC_MODE_TIMER && tk.tick && gate_ok |-> pulse)
      else $error("internal timer missed a tick");

   a_ext_clock: assert property ( // [RQ5]
      mode == QEC_MODE_EXT_GATE && a_rise && (!external_gate_enable || phase_b_input) && !pos_wr
      |=> pos_q != $past(pos_q))
      else $error("phase A edge not counted");

   a_ext_dir: assert property ( // [RQ6]
      mode == QEC_MODE_EXT_DIR && a_rise && phase_b_input && gate_ok && !pos_wr
      |=> pos_q == $past(pos_q) + 32'h0000_0001)
      else $error("phase B high did not count up");

   a_x4_step: assert property ( // [RQ7]
      mode == QEC_MODE_X4 && x4_edge && gate_ok && !match && !pos_wr
      |=> pos_q == ($past(up) ? $past(pos_q) + 32'h0000_0001
                                : $past(pos_q) - 32'h0000_0001))
      else $error("quadrature edge not stepped");

   a_vel_capture: assert property ( // [RQ11]
      s_vel_read |=> hreadyout_q && hrdata_q == vel_hold_q)
      else $error("velocity hold differs from value read");

   a_int_capture: assert property ( // [RQ12]
      pulse |=> int_hold_q == $past(int_tmr_q) && int_tmr_q == 32'h0000_0000)
      else $error("interval not captured and cleared");

   a_read_wait: assert property (
      req && !hwrite |=> !hreadyout_q ##1 hreadyout_q)
      else $error("read did not finish after one wait");

endmodule : qec_counter_ctrl

//--- qec_encoder_model.sv
// encoder phase, direction and gate source facing the counter block
`timescale 1ns/100ps
module qec_encoder_model (
   // clock
   input  wire logic hclk,
   // encoder pins
   output      logic phase_a_input,
   output      logic phase_b_input,
   output      logic gate_input
);
   logic [1:0] step_q;

   initial begin
      phase_a_input = 1'h0;
      phase_b_input = 1'h0;
      gate_input    = 1'h1;
      step_q        = 2'h0;
   end

   // one gray-code step, a leads b going up; the quiet cycles keep the
   // step rate at no more than half the counter clock
   task automatic step(input logic up);
      @(posedge hclk);
      step_q = up ? step_q + 2'h1 : step_q - 2'h1;
      phase_a_input <= step_q[1] ^ step_q[0];
      phase_b_input <= step_q[1];
      repeat (3) @(posedge hclk);
   endtask : step

   // rising edges of two calls in a row lie exactly gap cycles apart
   task automatic pulse_a(input int gap);
      @(posedge hclk);
      phase_a_input <= 1'h1;
      @(posedge hclk);
      phase_a_input <= 1'h0;
      repeat (gap - 2) @(posedge hclk);
   endtask : pulse_a

   task automatic hold_b(input logic v);
      @(posedge hclk);
      phase_b_input <= v;
   endtask : hold_b

   task automatic hold_gate(input logic v);
      @(posedge hclk);
      gate_input <= v;
   endtask : hold_gate

   // phase b high across exactly n sampling edges
   task automatic run_b(input int n);
      @(posedge hclk);
      phase_b_input <= 1'h1;
      repeat (n) @(posedge hclk);
      phase_b_input <= 1'h0;
   endtask : run_b
endmodule : qec_encoder_model

//--- test_qec_counter_ctrl.sv
// self-checking bench for the encoder counter control block
`timescale 1ns/100ps
module test_qec_counter_ctrl
   import qec_pkg::*;
();
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        phase_a_input;
   logic        phase_b_input;
   logic        gate_input;
   logic [31:0] rd_s;
   logic [31:0] h1;
   logic        hresp;
   logic [2:0]  hsz;
   logic [23:0] page;
   int          cyc;
   int          c0;
   int          fails;
   int          tests_run;

   initial begin
      hclk = 1'h0;
      forever #5 hclk = ~hclk;
   end

   // cycle count, runs in step with the prescaler counter
   always @(posedge hclk) begin
      cyc <= cyc + 1;
   end

   qec_counter_ctrl qec_counter_ctrl_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .phase_a_input(phase_a_input), .phase_b_input(phase_b_input),
      .gate_input(gate_input));

   qec_encoder_model qec_encoder_model_inst (
      .hclk(hclk), .phase_a_input(phase_a_input), .phase_b_input(phase_b_input),
      .gate_input(gate_input));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // hready, hrdata and hresp are taken at the rising edge that ends the phase
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'h1 && n < 100) begin
         n++;
         @(posedge hclk);
      end
      if (n == 100) begin
         fails++;
      end
      rd_s = hrdata;
      chk("hresp", 32'(QEC_HRESP_OKAY), 32'(hresp));
   endtask : wait_ready

   task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
      @(posedge hclk);
      // upper address bits are not decoded; flipping them proves it
      page = ~page;
      hsel   <= 1'h1;
      htrans <= 2'h2;
      haddr  <= {page, ofs};
      hwrite <= wr;
      hsize  <= hsz;
      wait_ready();
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
   endtask : bus

   task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
      bus(1'h1, ofs, wd);
   endtask : wr

   task automatic rchk(input logic [7:0] ofs, input logic [31:0] exp);
      bus(1'h0, ofs, 32'h0);
      chk($sformatf("offset %h", ofs), exp, rd_s);
   endtask : rchk

   task automatic pos_is(input logic [31:0] exp);
      rchk(QEC_OFS_POSITION, exp);
   endtask : pos_is

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   // the whole sequence needs well under 20000 cycles
   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      results();
   end

   initial begin
      hresetn = 1'h0;
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h0;
      hwdata = 32'h0;
      hsz = QEC_HSIZE_WORD;
      page = 24'h00_0000;
      fails = 0;
      tests_run = 0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'h1;
      // reset values, masked control, read-only and unmapped places
      for (int i = 0; i < 8; i++) begin
         if (i != 4) begin
            rchk(8'(i * 4), QEC_COUNT_RESET);
         end
      end
      wr(QEC_OFS_CONTROL, 32'hFFFF_FFF0);
      rchk(QEC_OFS_CONTROL, QEC_CONTROL_MASK & 32'hFFFF_FFF0);
      wr(QEC_OFS_VELOCITY, 32'h0000_00A5);
      rchk(QEC_OFS_VELOCITY, QEC_COUNT_RESET);
      wr(8'h1C, 32'h0000_00A5);
      rchk(8'h1C, 32'h0000_0000);
      wr(QEC_OFS_VEL_HOLD, 32'h1234_5678);
      rchk(QEC_OFS_VEL_HOLD, 32'h1234_5678);
      // a halfword write must be ignored
      hsz = 3'h1;
      wr(QEC_OFS_VEL_HOLD, 32'h0000_00A5);
      hsz = QEC_HSIZE_WORD;
      rchk(QEC_OFS_VEL_HOLD, 32'h1234_5678);
      wr(QEC_OFS_CONTROL, QEC_CONTROL_RESET);
      $display("test registers finished");
      // x4 decoding; match value 00 clears position on entering state 00
      repeat (3) qec_encoder_model_inst.step(1'h1);
      pos_is(32'h0000_0003);
      repeat (2) qec_encoder_model_inst.step(1'h0);
      pos_is(32'h0000_0001);
      qec_encoder_model_inst.step(1'h0);
      pos_is(32'h0000_0000);
      wr(QEC_OFS_CONTROL, 32'h0000_0008);
      repeat (3) qec_encoder_model_inst.step(1'h1);
      pos_is(32'hFFFF_FFFD);
      rchk(QEC_OFS_VELOCITY, 32'hFFFF_FFFD);
      rchk(QEC_OFS_VEL_HOLD, 32'hFFFF_FFFD);
      repeat (3) qec_encoder_model_inst.step(1'h0);
      pos_is(32'h0000_0000);
      $display("test quadrature finished");
      // phase a clock, phase b direction, init mode set but ignored
      wr(QEC_OFS_CONTROL, 32'h0000_0701);
      wr(QEC_OFS_POSITION, 32'h0000_0100);
      qec_encoder_model_inst.hold_b(1'h1);
      repeat (2) qec_encoder_model_inst.pulse_a(4);
      pos_is(32'h0000_0102);
      qec_encoder_model_inst.hold_b(1'h0);
      qec_encoder_model_inst.pulse_a(4);
      pos_is(32'h0000_0101);
      wr(QEC_OFS_CONTROL, 32'h0000_0705);
      qec_encoder_model_inst.hold_gate(1'h0);
      qec_encoder_model_inst.pulse_a(4);
      pos_is(32'h0000_0101);
      qec_encoder_model_inst.hold_gate(1'h1);
      qec_encoder_model_inst.pulse_a(4);
      pos_is(32'h0000_0100);
      wr(QEC_OFS_CONTROL, 32'h0000_0701);
      qec_encoder_model_inst.hold_gate(1'h0);
      qec_encoder_model_inst.pulse_a(4);
      pos_is(32'h0000_00FF);
      rchk(QEC_OFS_INDEX, 32'h0000_0000);
      qec_encoder_model_inst.hold_gate(1'h1);
      $display("test direction input finished");
      // phase b gates the external clock, then the internal timer
      wr(QEC_OFS_CONTROL, 32'h0000_0006);
      wr(QEC_OFS_POSITION, 32'h0000_0020);
      repeat (2) qec_encoder_model_inst.pulse_a(4);
      pos_is(32'h0000_0020);
      qec_encoder_model_inst.hold_b(1'h1);
      repeat (2) qec_encoder_model_inst.pulse_a(4);
      pos_is(32'h0000_0022);
      qec_encoder_model_inst.hold_b(1'h0);
      wr(QEC_OFS_CONTROL, 32'h0000_0007);
      wr(QEC_OFS_POSITION, 32'h0000_0055);
      repeat (20) @(posedge hclk);
      pos_is(32'h0000_0055);
      qec_encoder_model_inst.run_b(10);
      pos_is(32'h0000_005F);
      wr(QEC_OFS_CONTROL, 32'h0000_000F);
      qec_encoder_model_inst.run_b(10);
      pos_is(32'h0000_0055);
      $display("test gated modes finished");
      // spans of 4 and 9 prescaled periods must differ by exactly 5
      for (int s = 0; s < 8; s++) begin
         wr(QEC_OFS_CONTROL, 32'(s << QEC_DIV_LSB) | 32'h0000_0002);
         c0 = cyc;
         qec_encoder_model_inst.pulse_a(4 << s);
         qec_encoder_model_inst.pulse_a(4);
         bus(1'h0, QEC_OFS_INT_HOLD, 32'h0);
         h1 = rd_s;
         // start the long span on the same prescaler phase as the short one,
         // else a tick lost under a pulse makes the spans differ by 4 or 6
         while ((cyc - c0) % (1 << s) != 0) begin
            @(posedge hclk);
         end
         qec_encoder_model_inst.pulse_a(9 << s);
         qec_encoder_model_inst.pulse_a(4);
         bus(1'h0, QEC_OFS_INT_HOLD, 32'h0);
         chk("interval span", 32'h0000_0005, rd_s - h1);
      end
      $display("test interval prescale finished");
      results();
   end
endmodule : test_qec_counter_ctrl
